// *** shared/bdm_map.svh ***
// Address map, decode bit positions and reset values of the bus decode block.
// Assumes it is included by bare name from design and bench files alike.
`ifndef BDM_MAP_SVH
`define BDM_MAP_SVH

// ****************************************
// Decode bit positions
// ****************************************
`define BDM_A15        15
`define BDM_A11        11
`define BDM_HSEL_HI    14
`define BDM_HSEL_LO    12
`define BDM_FEN_A5     5
`define BDM_FEN_A4     4
`define BDM_FSEL_HI    2
`define BDM_FSEL_LO    0
`define BDM_RAM_AW     11

// ****************************************
// High decoder output assignment
// ****************************************
`define BDM_Y_ROM1     0
`define BDM_Y_FREQ     1
`define BDM_Y_RAM      2
`define BDM_Y_ROM2     4

// ****************************************
// Frequency register map
// ****************************************
`define BDM_FREQ_COUNT 6
`define BDM_FREQ_BASE  16'h1030
`define BDM_FREQ_LAST  16'h1035
`define BDM_REG_RF_LO  0
`define BDM_REG_RF_MID 1
`define BDM_REG_RF_UP  2
`define BDM_REG_MIXED  3
`define BDM_REG_BEAT   4
`define BDM_REG_SIXTH  5

// ****************************************
// Reset values
// ****************************************
`define BDM_RESET_BYTE 8'h00
`define BDM_RESET_ADDR 16'h0000

`endif

// *** shared/bdm_pkg.sv ***
// Types shared by the bus decode block and its bench.
// Assumes nothing beyond a SystemVerilog compiler.
package bdm_pkg;

  // Processor bus pins as seen at the board edge.
  typedef struct packed {
    logic       ale;
    logic       rd_n;
    logic       wr_n;
    logic [7:0] a_hi;
    logic [7:0] ad;
  } bdm_cpu_bus_type;

  // The six write-only frequency latches, index 0 at the lowest address.
  typedef logic [5:0][7:0] bdm_freq_regs_type;

endpackage : bdm_pkg

// *** src/bdm_bus_decode.sv ***
// Bus decode, address latch, static RAM and frequency latches of a processor board.
// Assumes the processor pins arrive asynchronously and are slow against clk.
`timescale 1ns/100ps
`include "bdm_map.svh"

module bdm_bus_decode
  import bdm_pkg::*;
#(
  parameter int RAM_AW = `BDM_RAM_AW
)
(
  // Clock, reset and enable
  input  wire logic              clk,
  input  wire logic              resetn,
  input  wire logic              ce,
  // Processor pins
  input  wire bdm_cpu_bus_type   cpu_pins,
  // Program memory controls
  output logic                   rom1_cs_n,
  output logic                   rom2_cs_n,
  output logic                   rom_oe_n,
  // Static RAM controls
  output logic                   ram_cs_n,
  output logic                   ram_rd_n,
  output logic                   ram_wr_n,
  // Board data driven by the RAM
  output logic [7:0]             board_data_out,
  output logic                   board_data_oe_n,
  // Transceiver direction
  output logic                   xcvr_toward_cpu,
  // Held address
  output logic [15:0]            latched_addr,
  // Frequency latches
  output logic [5:0]             freq_strobe_n,
  output bdm_freq_regs_type      freq_regs,
  output logic [25:0]            rf_freq_bcd,
  output logic                   beat_plus,
  output logic                   beat_minus,
  output logic [11:0]            beat_bcd
);

  // ****************************************
  // Declarations
  // ****************************************
  bdm_cpu_bus_type   sync1_ff;
  bdm_cpu_bus_type   sync2_ff;
  logic              ale_prev_ff;
  logic              wr_prev_ff;
  logic [15:0]       addr_ff;
  logic [7:0]        wr_data_ff;
  logic              rd_act_ff;
  logic [7:0]        hi_y_n;
  logic [7:0]        fq_y_n;
  logic              rom1_sel;
  logic              rom2_sel;
  logic              ram_sel;
  logic              ale_fall;
  logic              wr_rise;
  logic              rd_act;
  logic              ram_we;
  logic [7:0]        ram_rdata;
  logic              fq_en_n;
  bdm_freq_regs_type freq_regs_ff;
  logic [5:0]        freq_strobe_n_ff;

  // ****************************************
  // Shared decode function
  // ****************************************
  // Three-to-eight decoder with one positive and two negative enables.
  function automatic logic [7:0] dec8_n(
    input logic       g1,
    input logic       g2a_n,
    input logic       g2b_n,
    input logic [2:0] sel
  );
    logic [7:0] y;
    y = 8'hff;
    if (g1 && !g2a_n && !g2b_n)
    begin
      y[sel] = 1'h0;
    end
    return y;
  endfunction : dec8_n

  // ****************************************
  // Pin synchronisers
  // ****************************************
  // The processor pins are asynchronous; only the second stage is read.
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      sync1_ff <= '{ale: 1'h0, rd_n: 1'h1, wr_n: 1'h1, a_hi: 8'h00, ad: 8'h00};
      sync2_ff <= '{ale: 1'h0, rd_n: 1'h1, wr_n: 1'h1, a_hi: 8'h00, ad: 8'h00};
    end
    else if (ce)
    begin
      sync1_ff <= cpu_pins;
      sync2_ff <= sync1_ff;
    end
  end

  // Edge history of the strobes.
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      ale_prev_ff <= 1'h0;
      wr_prev_ff  <= 1'h1;
    end
    else if (ce)
    begin
      ale_prev_ff <= sync2_ff.ale;
      wr_prev_ff  <= sync2_ff.wr_n;
    end
  end

  assign ale_fall = ale_prev_ff & ~sync2_ff.ale;
  assign wr_rise  = ~wr_prev_ff & sync2_ff.wr_n;

  // ****************************************
  // Address latch
  // ****************************************
  // Both bytes are taken together so the decode never sees a mixed address.
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      addr_ff <= `BDM_RESET_ADDR;
    end
    else if (ce && ale_fall)
    begin
      addr_ff <= {sync2_ff.a_hi, sync2_ff.ad};
    end
  end

  // Data byte of a write cycle, refreshed while the write strobe is low.
  // The strobe rise then uses the last byte seen, as the bus may float after it.
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      wr_data_ff <= `BDM_RESET_BYTE;
    end
    else if (ce && !sync2_ff.wr_n)
    begin
      wr_data_ff <= sync2_ff.ad;
    end
  end

  // ****************************************
  // High-order decode
  // ****************************************
  always_comb
  begin
    // bits 14 to 12 as select
    hi_y_n = dec8_n(1'h1, 1'h0, addr_ff[`BDM_A15],
                    addr_ff[`BDM_HSEL_HI:`BDM_HSEL_LO]);
  end

  assign rom1_sel = ~hi_y_n[`BDM_Y_ROM1];
  assign rom2_sel = ~hi_y_n[`BDM_Y_ROM2];

  // RAM window needs bit 11 low as well
  assign ram_sel  = ~hi_y_n[`BDM_Y_RAM] & ~addr_ff[`BDM_A11];

  // ****************************************
  // Frequency strobe decode
  // ****************************************
  // Bits 11 to 6 and bit 3 are not decoded, so the six latches repeat through the nibble.
  assign fq_en_n = ~(addr_ff[`BDM_FEN_A5] & addr_ff[`BDM_FEN_A4]);

  always_comb
  begin
    fq_y_n = dec8_n(~sync2_ff.wr_n, fq_en_n, hi_y_n[`BDM_Y_FREQ],
                    addr_ff[`BDM_FSEL_HI:`BDM_FSEL_LO]);
  end

  // Registered strobes; they fall with the write strobe and rise with it.
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      freq_strobe_n_ff <= 6'h3f;
    end
    else if (ce)
    begin
      freq_strobe_n_ff <= fq_y_n[`BDM_FREQ_COUNT-1:0];
    end
  end

  // ****************************************
  // Frequency latches
  // ****************************************
  // A read never reaches here because the decoder needs the write strobe.
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      for (int i = 0; i < `BDM_FREQ_COUNT; i++)
      begin
        freq_regs_ff[i] <= `BDM_RESET_BYTE;
      end
    end
    else if (ce && wr_rise)
    begin
      for (int i = 0; i < `BDM_FREQ_COUNT; i++)
      begin
        if (!freq_strobe_n_ff[i])
        begin
          freq_regs_ff[i] <= wr_data_ff;
        end
      end
    end
  end

  // ****************************************
  // Frequency word unpacking
  // ****************************************
  // Most significant digit first; the top RF digit has only two bits.
  // RF digit layout
  assign rf_freq_bcd = {freq_regs_ff[`BDM_REG_MIXED][7:6],
                        freq_regs_ff[`BDM_REG_RF_UP][3:0],
                        freq_regs_ff[`BDM_REG_RF_UP][7:4],
                        freq_regs_ff[`BDM_REG_RF_MID][3:0],
                        freq_regs_ff[`BDM_REG_RF_MID][7:4],
                        freq_regs_ff[`BDM_REG_RF_LO][3:0],
                        freq_regs_ff[`BDM_REG_RF_LO][7:4]};

  assign beat_plus  = freq_regs_ff[`BDM_REG_MIXED][5];
  assign beat_minus = freq_regs_ff[`BDM_REG_MIXED][4];
  assign beat_bcd   = {freq_regs_ff[`BDM_REG_BEAT][3:0],
                       freq_regs_ff[`BDM_REG_BEAT][7:4],
                       freq_regs_ff[`BDM_REG_MIXED][3:0]};

  assign freq_regs     = freq_regs_ff;
  assign freq_strobe_n = freq_strobe_n_ff;

  // ****************************************
  // Static RAM
  // ****************************************
  // store on write strobe rise
  assign ram_we = wr_rise & ram_sel;
  assign rd_act = ram_sel & ~sync2_ff.rd_n;

  bdm_static_ram #(
    .AW (RAM_AW),
    .DW (8)
  ) u_static_ram (
    .clk    (clk),
    .resetn (resetn),
    .ce     (ce),
    .we     (ram_we),
    .addr   (addr_ff[RAM_AW-1:0]),
    .wdata  (wr_data_ff),
    .rdata  (ram_rdata)
  );

  // The array answers one cycle late, so the enable is delayed to match.
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      rd_act_ff <= 1'h0;
    end
    else if (ce)
    begin
      rd_act_ff <= rd_act;
    end
  end

  // ****************************************
  // Output registers
  // ****************************************
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      rom1_cs_n <= 1'h1;
      rom2_cs_n <= 1'h1;
      rom_oe_n  <= 1'h1;
    end
    else if (ce)
    begin
      // a high select keeps the memory off the bus
      rom1_cs_n <= ~rom1_sel;
      rom2_cs_n <= ~rom2_sel;
      rom_oe_n  <= sync2_ff.rd_n;
    end
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      ram_cs_n <= 1'h1;
      ram_rd_n <= 1'h1;
      ram_wr_n <= 1'h1;
    end
    else if (ce)
    begin
      ram_cs_n <= ~ram_sel;
      ram_rd_n <= sync2_ff.rd_n;
      ram_wr_n <= sync2_ff.wr_n;
    end
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      board_data_out  <= 8'h00;
      board_data_oe_n <= 1'h1;
    end
    else if (ce)
    begin
      board_data_out  <= ram_rdata;
      // drive only during a selected read
      board_data_oe_n <= ~(rd_act_ff & rd_act);
    end
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      xcvr_toward_cpu <= 1'h0;
    end
    else if (ce)
    begin
      xcvr_toward_cpu <= ~sync2_ff.rd_n;
    end
  end

  assign latched_addr = addr_ff;

endmodule : bdm_bus_decode

// *** src/bdm_static_ram.sv ***
// Static RAM array of the bus decode block.
// Assumes the caller has already decoded select and strobe timing.
`timescale 1ns/100ps

module bdm_static_ram
  import bdm_pkg::*;
#(
  parameter int AW = 11,
  parameter int DW = 8
)
(
  // Clock, reset and enable
  input  wire logic          clk,
  input  wire logic          resetn,
  input  wire logic          ce,
  // Access port
  input  wire logic          we,
  input  wire logic [AW-1:0] addr,
  input  wire logic [DW-1:0] wdata,
  output logic      [DW-1:0] rdata
);

  // The array carries no reset, as a real RAM powers up with arbitrary content.
  logic [DW-1:0] mem [0:(1<<AW)-1];

  always_ff @(posedge clk)
  begin
    if (ce && we)
    begin
      mem[addr] <= wdata;
    end
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      rdata <= '0;
    end
    else if (ce)
    begin
      rdata <= mem[addr];
    end
  end

endmodule : bdm_static_ram

// *** tb/bdm_bus_decode_checker.sv ***
// Concurrent checks on the ports of the bus decode block.
// Assumes clk runs freely and the processor pins stay idle while reset is low.
`timescale 1ns/100ps

module bdm_bus_decode_checker
  import bdm_pkg::*;
(
  // Clock, reset and enable
  input wire logic              clk,
  input wire logic              resetn,
  input wire logic              ce,
  // Watched ports
  input wire bdm_cpu_bus_type   cpu_pins,
  input wire logic              rom1_cs_n,
  input wire logic              rom2_cs_n,
  input wire logic              rom_oe_n,
  input wire logic              ram_cs_n,
  input wire logic              ram_rd_n,
  input wire logic              ram_wr_n,
  input wire logic              board_data_oe_n,
  input wire logic              xcvr_toward_cpu,
  input wire logic [15:0]       latched_addr,
  input wire logic [5:0]        freq_strobe_n,
  input wire bdm_freq_regs_type freq_regs
);
  logic [2:0] age_ff;
  logic       ready;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!resetn);

  // Pin history of $past reaches back before reset or a frozen spell for a few edges, so wait it out.
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      age_ff <= 3'h0;
    else if (!ce)
      age_ff <= 3'h0;
    else if (age_ff != 3'h5)
      age_ff <= age_ff + 3'h1;
  end
  assign ready = (age_ff == 3'h5);

  chk_ram_rd_follow: assert property (ready |-> ram_rd_n == $past(cpu_pins.rd_n, 3))
    else $error("ram read control lags the read strobe wrongly");
  chk_xcvr_dir: assert property (ready |-> xcvr_toward_cpu == !$past(cpu_pins.rd_n, 3))
    else $error("transceiver direction wrong");
  chk_rom_oe_follow: assert property (ready |-> rom_oe_n == $past(cpu_pins.rd_n, 3))
    else $error("program memory output enable lags the read strobe wrongly");
  chk_ram_wr_follow: assert property (ready |-> ram_wr_n == $past(cpu_pins.wr_n, 3))
    else $error("ram write control lags the write strobe wrongly");
  chk_ram_select: assert property (ready |-> ram_cs_n == ($past(latched_addr[15:11]) != 5'h04))
    else $error("ram select wrong");
  chk_rom_select: assert property (ready |-> rom1_cs_n == ($past(latched_addr[15:12]) != 4'h0)
    && rom2_cs_n == ($past(latched_addr[15:12]) != 4'h4))
    else $error("program memory select wrong");
  chk_addr_hold: assert property (ready && latched_addr != $past(latched_addr)
    |-> $past(cpu_pins.ale, 4) && !$past(cpu_pins.ale, 3))
    else $error("address changed without an address strobe fall");
  chk_strobe_decode: assert property (freq_strobe_n != 6'h3f |-> !$past(cpu_pins.wr_n, 3)
    && latched_addr[15:12] == 4'h1 && latched_addr[5:4] == 2'h3
    && (~freq_strobe_n) == (6'h01 << latched_addr[2:0]))
    else $error("frequency strobe outside a write to its address");
  chk_latch_rise: assert property (ready && freq_regs != $past(freq_regs)
    |-> $past(freq_strobe_n) != 6'h3f && freq_strobe_n == 6'h3f)
    else $error("frequency latch changed without a strobe rise");
  chk_rom_quiet: assert property (!rom1_cs_n || !rom2_cs_n |-> board_data_oe_n)
    else $error("ram drives the bus while a program memory is selected");
  chk_oe_only_ram: assert property (!board_data_oe_n |-> !ram_cs_n && !ram_rd_n)
    else $error("data driven outside a ram read");

endmodule : bdm_bus_decode_checker

// *** tb/bdm_cpu_model.sv ***
// Processor bus model driving the multiplexed pins of the bus decode block.
// Assumes the bench calls bus_cycle only after reset is released.
`timescale 1ns/100ps

module bdm_cpu_model
  import bdm_pkg::*;
(
  // Clock
  input  wire logic       clk,
  // Board read path
  input  wire logic [7:0] rdata,
  input  wire logic       rdata_oe_n,
  // Processor pins
  output bdm_cpu_bus_type pins
);
  initial
  begin
    pins = {1'b0, 1'b1, 1'b1, 8'h00, 8'h00};
  end

  // Each phase spans several clocks so the block's synchronisers see it.
  task automatic bus_cycle(input logic wr, input logic [15:0] addr, input logic [7:0] wdata,
                           output logic [7:0] seen, output logic seen_oe_n);
    @(posedge clk);
    pins.ale  <= 1'b1;
    pins.a_hi <= addr[15:8];
    pins.ad   <= addr[7:0];
    repeat (6) @(posedge clk);
    pins.ale <= 1'b0;
    repeat (6) @(posedge clk);
    pins.ad   <= wr ? wdata : ~addr[7:0];
    pins.wr_n <= !wr;
    pins.rd_n <= wr;
    repeat (8) @(posedge clk);
    seen      = rdata;
    seen_oe_n = rdata_oe_n;
    pins.wr_n <= 1'b1;
    pins.rd_n <= 1'b1;
    repeat (6) @(posedge clk);
    // Released lines then show the complement of the last byte, not the byte itself.
    pins.ad <= ~pins.ad;
  endtask : bus_cycle

endmodule : bdm_cpu_model

// *** tb/tb.sv ***
// Self-checking bench for the bus decode block against a reference model.
// Assumes the design, checker and processor model are compiled before it.
`timescale 1ns/100ps
`include "bdm_map.svh"

module tb
  import bdm_pkg::*;
;
  logic              clk;
  logic              resetn;
  logic              ce;
  bdm_cpu_bus_type   cpu_pins;
  logic              rom1_cs_n, rom2_cs_n, rom_oe_n, ram_cs_n, ram_rd_n, ram_wr_n;
  logic [7:0]        board_data_out;
  logic              board_data_oe_n, xcvr_toward_cpu, beat_plus, beat_minus;
  logic [15:0]       latched_addr;
  logic [5:0]        freq_strobe_n;
  bdm_freq_regs_type freq_regs;
  logic [25:0]       rf_freq_bcd;
  logic [11:0]       beat_bcd;
  logic [7:0]        ram_m [int];
  logic [7:0]        freq_m [6];
  int                err_count;
  int                checked;

  bdm_cpu_model i_cpu (.clk(clk), .rdata(board_data_out), .rdata_oe_n(board_data_oe_n), .pins(cpu_pins));

  bdm_bus_decode i_dut (.clk(clk), .resetn(resetn), .ce(ce), .cpu_pins(cpu_pins), .rom1_cs_n(rom1_cs_n),
    .rom2_cs_n(rom2_cs_n), .rom_oe_n(rom_oe_n), .ram_cs_n(ram_cs_n), .ram_rd_n(ram_rd_n), .ram_wr_n(ram_wr_n),
    .board_data_out(board_data_out), .board_data_oe_n(board_data_oe_n), .xcvr_toward_cpu(xcvr_toward_cpu),
    .latched_addr(latched_addr), .freq_strobe_n(freq_strobe_n), .freq_regs(freq_regs),
    .rf_freq_bcd(rf_freq_bcd), .beat_plus(beat_plus), .beat_minus(beat_minus), .beat_bcd(beat_bcd));

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      err_count++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic results();
    $display("Comparisons %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : results

  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    logic [7:0] s;
    logic       o;
    i_cpu.bus_cycle(1'b1, a, d, s, o);
    if (a[15:11] == 5'h04)
      ram_m[a[10:0]] = d;
    if (a[15:12] == 4'h1 && a[5:4] == 2'h3 && a[2:0] < 3'h6)
      freq_m[a[2:0]] = d;
  endtask : wr

  task automatic rd(input logic [15:0] a);
    logic [7:0] s;
    logic       o;
    i_cpu.bus_cycle(1'b0, a, 8'h00, s, o);
    if (a[15:11] == 5'h04)
    begin
      check("ram read enable", o, 0);
      check("ram read data", s, ram_m[a[10:0]]);
    end
    else
      check("foreign read enable", o, 1);
  endtask : rd

  task automatic check_freq();
    for (int i = 0; i < 6; i++)
      check("frequency latch", freq_regs[i], freq_m[i]);
  endtask : check_freq

  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  initial
  begin
    repeat (10000) @(posedge clk);
    err_count++;
    results();
  end

  initial
  begin
    logic [3:0]  dg [10];
    logic [7:0]  b [6];
    logic [15:0] q [$];
    logic        p;
    logic [7:0]  s;
    logic        o;
    resetn = 1'b0;
    ce = 1'b1;
    foreach (freq_m[i])
      freq_m[i] = `BDM_RESET_BYTE;
    void'($urandom(32'h160a));
    repeat (5) @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
    check("address after reset", latched_addr, `BDM_RESET_ADDR);
    check_freq();
    $display("Test reset done");
    for (int n = 0; n < 2; n++)
    begin
      foreach (dg[k])
        dg[k] = 4'($urandom_range(9));
      p = 1'($urandom);
      b[0] = {dg[0], dg[1]};
      b[1] = {dg[2], dg[3]};
      b[2] = {dg[4], dg[5]};
      b[3] = {dg[6][1:0], p, !p, dg[7]};
      b[4] = {dg[8], dg[9]};
      b[5] = 8'($urandom);
      for (int i = 0; i < 6; i++)
        wr(`BDM_FREQ_BASE + 16'(i), b[i]);
      wr(16'h1036, 8'($urandom));
      wr(16'h1026, 8'($urandom));
      rd(16'h1031);
      check_freq();
      check("rf word", rf_freq_bcd, {dg[6][1:0], dg[5], dg[4], dg[3], dg[2], dg[1], dg[0]});
      check("beat word", {beat_plus, beat_minus, beat_bcd}, {p, !p, dg[9], dg[8], dg[7]});
    end
    $display("Test frequency latches done");
    wr(16'h2000, 8'haa);
    wr(16'h2800, 8'h55);
    wr(16'h27ff, 8'($urandom));
    for (int i = 0; i < 6; i++)
    begin
      q.push_back(16'h2000 | 16'($urandom_range(16'h7ff)));
      wr(q[i], 8'($urandom));
    end
    rd(16'h2000);
    rd(16'h27ff);
    foreach (q[i])
      rd(q[i]);
    rd(16'h0123);
    rd(16'h4abc);
    rd(16'ha123);
    rd(16'hc000);
    rd(16'h3000);
    check_freq();
    $display("Test memory map done");
    // With the enable low the block must ignore a whole write cycle to the first latch.
    ce <= 1'b0;
    i_cpu.bus_cycle(1'b1, `BDM_FREQ_BASE, 8'($urandom), s, o);
    ce <= 1'b1;
    repeat (6) @(posedge clk);
    check("address frozen", latched_addr, 16'h3000);
    check_freq();
    $display("Test clock enable done");
    results();
  end

endmodule : tb

bind bdm_bus_decode bdm_bus_decode_checker i_chk (.clk(clk), .resetn(resetn), .ce(ce), .cpu_pins(cpu_pins),
  .rom1_cs_n(rom1_cs_n), .rom2_cs_n(rom2_cs_n), .rom_oe_n(rom_oe_n), .ram_cs_n(ram_cs_n), .ram_rd_n(ram_rd_n),
  .ram_wr_n(ram_wr_n),
  .board_data_oe_n(board_data_oe_n), .xcvr_toward_cpu(xcvr_toward_cpu), .latched_addr(latched_addr),
  .freq_strobe_n(freq_strobe_n), .freq_regs(freq_regs));
